/* hw/ppw_pkg.sv */
package ppw_pkg;
	// Register word byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_PERIOD   = 8'h04;
	localparam logic [7:0] ADDR_PHASE    = 8'h08;
	localparam logic [7:0] ADDR_DUTY     = 8'h0c;
	localparam logic [7:0] ADDR_DEAD     = 8'h10;
	localparam logic [7:0] ADDR_STEER    = 8'h14;
	localparam logic [7:0] ADDR_SRC      = 8'h18;
	localparam logic [7:0] ADDR_STATUS   = 8'h1c;
	localparam logic [7:0] ADDR_FRAC     = 8'h20;
	// Control fields
	localparam int CTRL_EN     = 0;
	localparam int CTRL_LD     = 1;
	localparam int CTRL_3PH    = 2;
	localparam int CTRL_MODBIT = 3;
	localparam int CTRL_VARF   = 4;
	localparam int CTRL_SDCLR  = 5;
	localparam int CTRL_W      = 6;
	// Source select fields
	localparam int SRC_PER_LSB  = 0;
	localparam int SRC_RISE_LSB = 4;
	localparam int SRC_FALL_LSB = 8;
	localparam int SRC_MOD_LSB  = 12;
	localparam int SRC_MODEN    = 15;
	localparam int SRC_SD_LSB   = 16;
	localparam int SRC_W        = 20;
	// Steering control 1 fields
	localparam int STR_HSM = 6;
	localparam int STR_LSM = 7;
	localparam int CNT_W   = 16;
	localparam int DB_W    = 8;
	localparam int FRAC_W  = 4;
	localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
	localparam logic [CNT_W-1:0] DUTY_RST   = 16'h0000;
	localparam logic [31:0] BAD_READ = 32'h00000000;
endpackage : ppw_pkg

/* hw/ppw_event_src.sv */
`timescale 1ns/1ps
// One event: timed counter match OR-ed with selected asynchronous inputs
module ppw_event_src (
	input  wire logic                        clk_sys,   // System clock
	input  wire logic                        reset,     // Async reset
	input  wire logic [3:0]                  sel,       // Source enables
	input  wire logic                        match,     // Time-base match
	input  wire logic                        pin_in,    // External pin
	input  wire logic                        cmp1,      // Comparator 1
	input  wire logic                        cmp2,      // Comparator 2
	output logic                             evt        // Rising-edge event
);
	logic [2:0] prev_q;
	wire  [2:0] lvl = {cmp2, cmp1, pin_in};
	wire  [2:0] rise = lvl & ~prev_q;
	// Async sources fire on their rising edge only, not while held
	assign evt = (sel[0] & match) | (|(sel[3:1] & rise));
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			prev_q <= 3'h0;
		else
			prev_q <= lvl;
	end
endmodule : ppw_event_src

/* hw/ppw_core.sv */
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// How it works
// - Period event sets frequency, rising event starts pulse, falling ends it.
// - Each event type uses a software-selected mix of timed and async sources.
// - Async sources come from an input pin or comparator outputs.
// - Timed events come from the internally clocked time-base counter.
// - Active pulse gated by control bit, comparator, capture/compare, or pin.
// - Selectable dead time keeps complementary switches from both being on.
// - Variable-frequency mode adds a fractional period accumulator.
// - Shutdown input or any synced comparator, as selected, stops outputs.
// - In three-phase mode only one high and one low output are active.
// - Three-phase mode applies no dead band.
// - A/B, C/D, E/F are phase 1, 2, 3 high/low pairs.
// - Steering 01,02,04,08,10,20h select AD, AF, CF, CB, EB, ED.
// - Several steering bits set: lowest set bit wins.
// - High-side modulation enable switches high output by rise/fall events.
// - Low-side modulation enable switches low output by rise/fall events.
// - Both enables clear: selected outputs take rising state and hold.
// - Rising event drives modulated outputs active; falling drives inactive.
// - While disabled, buffered register writes go straight to active copy.
// - While enabled, load bit copies all buffers at next period, then clears.
module ppw_core (
	input  wire logic        clk_sys,                 // 25 MHz clock
	input  wire logic        reset,                   // Async reset
	input  wire logic        psel,                    // APB select
	input  wire logic        penable,                 // APB enable
	input  wire logic        pwrite,                  // APB direction
	input  wire logic [7:0]  paddr,                   // APB address
	input  wire logic [31:0] pwdata,                  // APB write data
	output logic      [31:0] prdata,                  // APB read data
	output logic             pready,                  // APB ready
	output logic             pslverr,                 // APB error
	input  wire logic        shutdown_input_pin,      // Shutdown / event pin
	input  wire logic        comparator1_synced_out,  // Comparator 1
	input  wire logic        comparator2_synced_out,  // Comparator 2
	input  wire logic        comparator3_synced_out,  // Comparator 3
	input  wire logic        capture_compare_output,  // CAPTURE_COMPARE_OUTPUT gate source
	input  wire logic        mod_input_pin,           // Gate input pin
	output logic             out_a,                   // Phase 1 high
	output logic             out_b,                   // Phase 1 low
	output logic             out_c,                   // Phase 2 high
	output logic             out_d,                   // Phase 2 low
	output logic             out_e,                   // Phase 3 high
	output logic             out_f                    // Phase 3 low
);
	localparam int CW = ppw_pkg::CNT_W;
	localparam int DW = ppw_pkg::DB_W;
	localparam int FW = ppw_pkg::FRAC_W;

	// Control and source registers
	logic [ppw_pkg::CTRL_W-1:0] ctrl_q;
	logic [ppw_pkg::SRC_W-1:0]  src_q;
	// Software-side copies of buffered registers
	logic [CW-1:0] per_w_q, pha_w_q, dut_w_q;
	logic [DW-1:0] dbr_w_q, dbf_w_q;
	logic [7:0]    str_w_q;
	logic [FW-1:0] frc_w_q;
	// Active copies
	logic [CW-1:0] per_q, pha_q, dut_q;
	logic [DW-1:0] dbr_q, dbf_q;
	logic [7:0]    str_q;
	logic [FW-1:0] frc_q;
	logic [CW-1:0] cnt_q;
	logic [FW:0]   acc_q;
	logic          pulse_q, sd_q;
	logic [DW-1:0] dr_q, df_q;
	logic          h_q, l_q;
	logic [31:0]   rd_mux;

	// APB decode: zero-wait, answer in access phase
	wire acc   = psel & penable;
	wire wr    = acc & pwrite;
	wire en    = ctrl_q[ppw_pkg::CTRL_EN];
	wire hit_c = paddr == ppw_pkg::ADDR_CTRL;
	wire hit_p = paddr == ppw_pkg::ADDR_PERIOD;
	wire hit_h = paddr == ppw_pkg::ADDR_PHASE;
	wire hit_d = paddr == ppw_pkg::ADDR_DUTY;
	wire hit_b = paddr == ppw_pkg::ADDR_DEAD;
	wire hit_s = paddr == ppw_pkg::ADDR_STEER;
	wire hit_r = paddr == ppw_pkg::ADDR_SRC;
	wire hit_t = paddr == ppw_pkg::ADDR_STATUS;
	wire hit_f = paddr == ppw_pkg::ADDR_FRAC;
	wire mapped = hit_c | hit_p | hit_h | hit_d | hit_b | hit_s | hit_r
		| hit_t | hit_f;

	// Time base and events
	wire m_per  = cnt_q >= per_q;
	wire m_rise = cnt_q == pha_q;
	wire m_fall = cnt_q == dut_q;
	wire e_per, e_rise, e_fall;
	ppw_event_src u_per (
		.clk_sys (clk_sys),
		.reset   (reset),
		.sel     (src_q[ppw_pkg::SRC_PER_LSB +: 4]),
		.match   (m_per & ~acc_q[FW]),
		.pin_in  (shutdown_input_pin),
		.cmp1    (comparator1_synced_out),
		.cmp2    (comparator2_synced_out),
		.evt     (e_per)
	);
	ppw_event_src u_rise (
		.clk_sys (clk_sys),
		.reset   (reset),
		.sel     (src_q[ppw_pkg::SRC_RISE_LSB +: 4]),
		.match   (m_rise),
		.pin_in  (shutdown_input_pin),
		.cmp1    (comparator1_synced_out),
		.cmp2    (comparator2_synced_out),
		.evt     (e_rise)
	);
	ppw_event_src u_fall (
		.clk_sys (clk_sys),
		.reset   (reset),
		.sel     (src_q[ppw_pkg::SRC_FALL_LSB +: 4]),
		.match   (m_fall),
		.pin_in  (shutdown_input_pin),
		.cmp1    (comparator1_synced_out),
		.cmp2    (comparator2_synced_out),
		.evt     (e_fall)
	);

	// Fraction overflow stretches a period by one count
	wire [FW:0] acc_nx = {1'b0, acc_q[FW-1:0]} + {1'b0, frc_q};
	wire varf = ctrl_q[ppw_pkg::CTRL_VARF];

	// Buffer load on period event while enabled
	wire ld_now = en & e_per & ctrl_q[ppw_pkg::CTRL_LD];
	wire direct = wr & ~en;

	// Pulse state: fall after rise in the same cycle wins inactive
	wire pulse_d = e_fall ? 1'b0 : (e_rise ? 1'b1 : pulse_q);

	// Modulation gate source
	wire [1:0] msel = src_q[ppw_pkg::SRC_MOD_LSB +: 2];
	wire gate_src = (msel == 2'h0) ? ctrl_q[ppw_pkg::CTRL_MODBIT] :
		(msel == 2'h1) ? comparator1_synced_out :
		(msel == 2'h2) ? capture_compare_output : mod_input_pin;
	wire gate = ~src_q[ppw_pkg::SRC_MODEN] | gate_src;
	wire act = pulse_q & gate;

	// Auto-shutdown triggers
	wire [3:0] sd_in = {comparator3_synced_out, comparator2_synced_out,
		comparator1_synced_out, shutdown_input_pin};
	wire sd_trig = |(sd_in & src_q[ppw_pkg::SRC_SD_LSB +: 4]);

	// Three-phase steering: isolate lowest set bit
	wire [5:0] st = str_q[5:0];
	wire [5:0] lsb = st & (~st + 6'h01);
	// High outputs {e,c,a}, low outputs {f,d,b}
	wire [2:0] hsel = {lsb[4] | lsb[5], lsb[2] | lsb[3],
		lsb[0] | lsb[1]};
	wire [2:0] lsel = {lsb[1] | lsb[2], lsb[0] | lsb[5],
		lsb[3] | lsb[4]};
	wire hsm = str_q[ppw_pkg::STR_HSM];
	wire lsm = str_q[ppw_pkg::STR_LSM];
	// Unmodulated side holds rising-edge (active) state
	wire hon = hsm ? act : 1'b1;
	wire lon = lsm ? act : 1'b1;
	wire tri_ph = ctrl_q[ppw_pkg::CTRL_3PH];

	// Dead time: delayed turn-on of each complementary side
	wire h_c = act;
	wire l_c = ~act;
	// Delay counts from the turn-on cycle itself, so no one-cycle glitch
	wire [DW-1:0] h_rem = (h_c & ~h_q) ? dbr_q : dr_q;
	wire [DW-1:0] l_rem = (l_c & ~l_q) ? dbf_q : df_q;
	wire h_dt = h_c & (h_rem == '0);
	wire l_dt = l_c & (l_rem == '0);

	wire run = en & ~sd_q;
	// Next output values; three-phase bypasses dead band
	wire [5:0] o3 = {lsel[2] & lon, hsel[2] & hon, lsel[1] & lon,
		hsel[1] & hon, lsel[0] & lon, hsel[0] & hon};
	wire [5:0] o2 = {4'h0, l_dt, h_dt};
	wire [5:0] onx = ~run ? 6'h00 : (tri_ph ? o3 : o2);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl_q  <= '0;
			src_q   <= '0;
			per_w_q <= ppw_pkg::PERIOD_RST;
			pha_w_q <= ppw_pkg::DUTY_RST;
			dut_w_q <= ppw_pkg::DUTY_RST;
			dbr_w_q <= '0;
			dbf_w_q <= '0;
			str_w_q <= '0;
			frc_w_q <= '0;
		end else begin
			if (wr & hit_c)
				ctrl_q <= pwdata[ppw_pkg::CTRL_W-1:0];
			else if (ld_now)
				ctrl_q[ppw_pkg::CTRL_LD] <= 1'b0;
			if (wr & hit_r)
				src_q <= pwdata[ppw_pkg::SRC_W-1:0];
			if (wr & hit_p)
				per_w_q <= pwdata[CW-1:0];
			if (wr & hit_h)
				pha_w_q <= pwdata[CW-1:0];
			if (wr & hit_d)
				dut_w_q <= pwdata[CW-1:0];
			if (wr & hit_b) begin
				dbr_w_q <= pwdata[DW-1:0];
				dbf_w_q <= pwdata[2*DW-1:DW];
			end
			if (wr & hit_s)
				str_w_q <= pwdata[7:0];
			if (wr & hit_f)
				frc_w_q <= pwdata[FW-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			per_q <= ppw_pkg::PERIOD_RST;
			pha_q <= ppw_pkg::DUTY_RST;
			dut_q <= ppw_pkg::DUTY_RST;
			dbr_q <= '0;
			dbf_q <= '0;
			str_q <= '0;
			frc_q <= '0;
		end else if (ld_now) begin
			per_q <= per_w_q;
			pha_q <= pha_w_q;
			dut_q <= dut_w_q;
			dbr_q <= dbr_w_q;
			dbf_q <= dbf_w_q;
			str_q <= str_w_q;
			frc_q <= frc_w_q;
		end else if (direct) begin
			if (hit_p)
				per_q <= pwdata[CW-1:0];
			if (hit_h)
				pha_q <= pwdata[CW-1:0];
			if (hit_d)
				dut_q <= pwdata[CW-1:0];
			if (hit_b) begin
				dbr_q <= pwdata[DW-1:0];
				dbf_q <= pwdata[2*DW-1:DW];
			end
			if (hit_s)
				str_q <= pwdata[7:0];
			if (hit_f)
				frc_q <= pwdata[FW-1:0];
		end
	end

	// Time base, pulse, shutdown
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_q   <= '0;
			acc_q   <= '0;
			pulse_q <= 1'b0;
			sd_q    <= 1'b0;
		end else if (!en) begin
			cnt_q   <= '0;
			acc_q   <= '0;
			pulse_q <= 1'b0;
			sd_q    <= 1'b0;
		end else begin
			if (e_per) begin
				cnt_q <= '0;
				if (varf)
					acc_q <= acc_nx;
				else
					acc_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
				if (m_per)
					acc_q[FW] <= 1'b0;
			end
			pulse_q <= pulse_d;
			// Shutdown sticks until software clears; trigger wins
			if (sd_trig)
				sd_q <= 1'b1;
			else if (wr & hit_c & pwdata[ppw_pkg::CTRL_SDCLR])
				sd_q <= 1'b0;
		end
	end

	// Dead-time counters restart on each opposite transition
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dr_q <= '0;
			df_q <= '0;
			h_q  <= 1'b0;
			l_q  <= 1'b0;
		end else begin
			h_q <= h_c;
			l_q <= l_c;
			dr_q <= (h_rem != '0) ? h_rem - 1'b1 : '0;
			df_q <= (l_rem != '0) ? l_rem - 1'b1 : '0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			{out_f, out_e, out_d, out_c, out_b, out_a} <= 6'h00;
		else
			{out_f, out_e, out_d, out_c, out_b, out_a} <= onx;
	end

	// APB answer registered in setup phase, ready next cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (psel & ~penable & ~pwrite)
				prdata <= rd_mux;
		end
	end

	always_comb begin
		rd_mux = ppw_pkg::BAD_READ;
		if (hit_c)
			rd_mux = {26'h0, ctrl_q};
		if (hit_p)
			rd_mux = {16'h0, per_w_q};
		if (hit_h)
			rd_mux = {16'h0, pha_w_q};
		if (hit_d)
			rd_mux = {16'h0, dut_w_q};
		if (hit_b)
			rd_mux = {16'h0, dbf_w_q, dbr_w_q};
		if (hit_s)
			rd_mux = {24'h0, str_w_q};
		if (hit_r)
			rd_mux = {12'h0, src_q};
		if (hit_f)
			rd_mux = {28'h0, frc_w_q};
		if (hit_t)
			rd_mux = {sd_q, pulse_q, 14'h0, cnt_q};
	end
endmodule : ppw_core

/* verification/ppw_bridge_model.sv */
`timescale 1ns/1ps
// Three half-bridges; both switches of one leg on shorts the rail
module ppw_bridge_model (
	input  wire logic       clk_sys,   // Clock
	input  wire logic [5:0] gate,      // {f,e,d,c,b,a} gate drives
	output logic      [7:0] shoot_cnt  // Shorted-leg cycles seen
);
	logic [2:0] short_w;
	// Leg n: high switch gate[2n], low switch gate[2n+1]
	assign short_w = {gate[4] & gate[5], gate[2] & gate[3], gate[0] & gate[1]};
	initial shoot_cnt = 8'h00;
	always @(posedge clk_sys) begin
		if (|short_w) begin
			shoot_cnt <= shoot_cnt + 8'h01;
		end
	end
endmodule : ppw_bridge_model

/* verification/ppw_checker.sv */
`timescale 1ns/1ps
module ppw_checker (
	input wire logic       clk_sys, // Clock
	input wire logic       reset,   // Async reset
	input wire logic       psel,    // APB select
	input wire logic       penable, // APB enable
	input wire logic [7:0] paddr,   // APB address
	input wire logic       pready,  // APB ready
	input wire logic       pslverr, // APB error
	input wire logic       out_a,   // Phase 1 high
	input wire logic       out_b,   // Phase 1 low
	input wire logic       out_c,   // Phase 2 high
	input wire logic       out_d,   // Phase 2 low
	input wire logic       out_e,   // Phase 3 high
	input wire logic       out_f    // Phase 3 low
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_bad;
		s_setup ##0 (paddr > 8'h20);
	endsequence
	sequence s_good;
		s_setup ##0 (paddr <= 8'h20 && paddr[1:0] == 2'b00);
	endsequence
	chk_ready_next: assert property (s_setup |=> pready) // [APB]
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready) // [APB]
		else $error("ready longer than one cycle");
	chk_ready_access: assert property (pready |-> psel && penable) // [APB]
		else $error("ready outside access");
	chk_err_unmapped: assert property (s_bad |=> pslverr) // [APB]
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (s_good |=> !pslverr) // [APB]
		else $error("mapped access refused");
	chk_leg1_excl: assert property (!(out_a && out_b))
		else $error("leg 1 both on");
	chk_leg2_excl: assert property (!(out_c && out_d))
		else $error("leg 2 both on");
	chk_leg3_excl: assert property (!(out_e && out_f))
		else $error("leg 3 both on");
	chk_two_active: assert property (
		$countones({out_a, out_b, out_c, out_d, out_e, out_f}) <= 2)
		else $error("more than two outputs on");
	chk_high_single: assert property (
		$countones({out_a, out_c, out_e}) <= 1)
		else $error("two high sides on");
endmodule : ppw_checker
bind ppw_core ppw_checker i_chk (.clk_sys(clk_sys), .reset(reset),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .out_a(out_a), .out_b(out_b), .out_c(out_c),
	.out_d(out_d), .out_e(out_e), .out_f(out_f));

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        clk_sys   = 1'b0;
	logic        reset     = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h00000000;
	logic [5:0]  ins       = 6'h00; // pin,c1,c2,c3,ccp,gate pin
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  outs;
	logic [7:0]  shoot_cnt;
	logic [31:0] seed      = 32'h00008dbd;
	logic [31:0] rd;
	logic        err;
	logic [5:0]  o;
	logic [5:0]  a;
	logic [7:0]  na;
	logic [7:0]  nb;
	logic [15:0] mx;
	int          fails     = 0;
	int          tests_run = 0;
	int          cycles    = 0;
	always #20 clk_sys = ~clk_sys;
	ppw_core i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.shutdown_input_pin(ins[0]), .comparator1_synced_out(ins[1]),
		.comparator2_synced_out(ins[2]), .comparator3_synced_out(ins[3]),
		.capture_compare_output(ins[4]), .mod_input_pin(ins[5]),
		.out_a(outs[0]), .out_b(outs[1]), .out_c(outs[2]), .out_d(outs[3]),
		.out_e(outs[4]), .out_f(outs[5]));
	ppw_bridge_model i_bridge (.clk_sys(clk_sys), .gate(outs),
		.shoot_cnt(shoot_cnt));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	// Output pattern {f..a} chosen by lowest set steering bit
	function automatic logic [5:0] pair(input logic [5:0] s);
		if (s[0]) return 6'h09;
		if (s[1]) return 6'h21;
		if (s[2]) return 6'h24;
		if (s[3]) return 6'h06;
		if (s[4]) return 6'h12;
		if (s[5]) return 6'h18;
		return 6'h00;
	endfunction : pair
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// No local limit: only the bench timeout ends a wait
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// OR, AND and out_a/out_b on-counts over two full periods
	task automatic watch;
		o = 6'h00;
		a = 6'h3f;
		na = 8'h00;
		nb = 8'h00;
		repeat (42) begin
			@(posedge clk_sys);
			o = o | outs;
			a = a & outs;
			na = na + {7'h00, outs[0]};
			nb = nb + {7'h00, outs[1]};
		end
	endtask : watch
	task automatic steer_case(input logic [7:0] s);
		logic [5:0] e;
		logic [5:0] h;
		e = pair(s[5:0]);
		// Modulated sides toggle, so they drop out of the AND
		h = e & ~{s[7], s[6], s[7], s[6], s[7], s[6]};
		seed = xs(seed);
		ins[5:4] <= seed[1:0];
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000004);
		apb(1'b1, ppw_pkg::ADDR_STEER, {24'h000000, s});
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000005);
		repeat (30) @(posedge clk_sys);
		watch();
		cmp(32'(o), 32'(e));
		cmp(32'(a), 32'(h));
	endtask : steer_case
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		apb(1'b0, ppw_pkg::ADDR_PERIOD, 32'h00000000);
		cmp(rd, 32'(ppw_pkg::PERIOD_RST));
		apb(1'b0, 8'h40, 32'h00000000);
		cmp(32'(err), 32'h00000001);
		cmp(rd, ppw_pkg::BAD_READ);
		apb(1'b1, ppw_pkg::ADDR_PERIOD, 32'h00000014);
		apb(1'b1, ppw_pkg::ADDR_PHASE, 32'h00000005);
		apb(1'b1, ppw_pkg::ADDR_DUTY, 32'h0000000a);
		apb(1'b1, ppw_pkg::ADDR_SRC, 32'h00000111);
		for (int i = 0; i < 7; i++) begin
			for (int m = 0; m < 4; m++) begin
				steer_case({m[1:0], 6'(1 << i)});
			end
		end
		repeat (6) begin
			seed = xs(seed);
			steer_case(seed[7:0]);
		end
		steer_case(8'h01);
		apb(1'b1, ppw_pkg::ADDR_STEER, 32'h00000004);
		watch();
		cmp(32'(o), 32'h00000009);
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000007);
		repeat (30) @(posedge clk_sys);
		watch();
		cmp(32'(o), 32'h00000024);
		apb(1'b0, ppw_pkg::ADDR_CTRL, 32'h00000000);
		cmp(32'(rd[1]), 32'h00000000);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000004);
			apb(1'b1, ppw_pkg::ADDR_SRC,
				32'h00000111 | (32'h00010000 << k));
			apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000005);
			repeat (30) @(posedge clk_sys);
			ins[k] <= 1'b1;
			@(posedge clk_sys);
			ins[k] <= 1'b0;
			repeat (4) @(posedge clk_sys);
			watch();
			cmp(32'(o), 32'h00000000);
			apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000025);
			repeat (30) @(posedge clk_sys);
			watch();
			cmp(32'(o), 32'h00000024);
		end
		// Two-output mode: pulse 5, period 21, rise delay 3, fall delay 2
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000000);
		apb(1'b1, ppw_pkg::ADDR_SRC, 32'h00000111);
		apb(1'b1, ppw_pkg::ADDR_DEAD, 32'h00000203);
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000001);
		repeat (30) @(posedge clk_sys);
		watch();
		cmp(32'(na), 32'h00000004);
		cmp(32'(nb), 32'h0000001c);
		steer_case(8'h41);
		cmp(32'(na), 32'h0000000a);
		// Gate from bit, cmp1, ccp, pin; low then high
		for (int j = 0; j < 8; j++) begin
			ins <= {j[2] & (j[1:0] == 2'h3), j[2] & (j[1:0] == 2'h2),
				2'h0, j[2] & (j[1:0] == 2'h1), 1'b0};
			apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000004);
			apb(1'b1, ppw_pkg::ADDR_SRC,
				32'h00008111 | {18'h0, j[1:0], 12'h000});
			apb(1'b1, ppw_pkg::ADDR_STEER, 32'h00000041);
			apb(1'b1, ppw_pkg::ADDR_CTRL,
				32'h00000005 | {28'h0, j[2], 3'h0});
			repeat (30) @(posedge clk_sys);
			watch();
			cmp(32'(o), 32'({5'h04, j[2]}));
		end
		ins <= 6'h00;
		// Rising event from the pin only
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000004);
		apb(1'b1, ppw_pkg::ADDR_SRC, 32'h00000121);
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000005);
		repeat (30) @(posedge clk_sys);
		watch();
		cmp(32'(o), 32'h00000008);
		fork
			watch();
			begin
				ins <= 6'h01;
				@(posedge clk_sys);
				ins <= 6'h00;
				repeat (3) @(posedge clk_sys);
				ins <= 6'h01;
				@(posedge clk_sys);
				ins <= 6'h00;
			end
		join
		cmp(32'(o), 32'h00000009);
		// Half-count fraction stretches every other period to 22
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000000);
		apb(1'b1, ppw_pkg::ADDR_SRC, 32'h00000111);
		apb(1'b1, ppw_pkg::ADDR_FRAC, 32'h00000008);
		apb(1'b1, ppw_pkg::ADDR_CTRL, 32'h00000011);
		mx = 16'h0000;
		repeat (43) begin
			apb(1'b0, ppw_pkg::ADDR_STATUS, 32'h00000000);
			if (rd[15:0] > mx) mx = rd[15:0];
		end
		cmp(32'(mx), 32'h00000015);
		cmp(32'(shoot_cnt), 32'h00000000);
		end_of_test();
	end
endmodule : testbench
